// ===== verilog/stgc_top.sv
// timing, power mode stepping and global configuration of the sensing controller
//--------------------------------------------------------------------
// What this block does
// - low power period counts one-millisecond steps
// - ultra-low power period counts sixteen-millisecond steps
// - ulp senses wake channel, others slower
// - power mode timer expiry steps mode
// - any threshold crossing restarts mode timer
// - attention window half-ms steps, 10 ms default
// - address poll answered after window lapse
// - halt expiry reseeds enabled channels
// - all-ones halt setting disables timed reseed
// - tuning allowed only in low power
// - band bit picks eighth or sixteenth
// - band check off accepts out-of-band tune
// - count filter disable passes raw counts
// - three-bit field picks touch output channel
// - one-sided: freeze falling, follow rising
// - two-sided: freeze both, trigger both
// - calcap 0.5 or 1.5 pF, enabled channels
// - transmit divider one, two, four, eight
// - reference event reseeds within level code
// - tracking enable disables reference reseed
// - tracking halts reference, subtracts weighted delta
// - slider filter raw to strong, not tap
// - byte marks event blocking channels
// - reseed loads average with present count
//--------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module stgc_top #(
  parameter int TICK_CYC = stgc_pkg::STGC_TICK_CYC,
  parameter int NCH = 8
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // register port
  input wire stgc_pkg::stgc_req_t I_REQ,
  output logic [15:0] O_RDATA,
  output logic O_RVALID,
  // sensing core status
  input wire stgc_pkg::stgc_sense_t I_SENSE,
  input wire logic I_ADDR_POLL,
  input wire logic I_HOST_ACCESS,
  input wire logic I_SAMPLE_START,
  // tuning core
  input wire logic I_TUNE_REQ,
  input wire logic I_TUNE_OUT_OF_BAND,
  // controls to the core
  output logic [1:0] O_MODE,
  output logic O_SAMPLE_TICK,
  output logic [7:0] O_SENSE_MASK,
  output logic [7:0] O_RESEED,
  output logic O_TUNE_EN,
  output logic O_TUNE_RETRY,
  output logic [3:0] O_BAND_SHIFT,
  output logic O_CNT_FILT_BYPASS,
  output logic O_TOUCH_FLAG,
  output logic O_TOUCH_FLAG_OE,
  output logic O_BIDIR,
  output logic O_FREEZE_UP,
  output logic [3:0] O_CALCAP_HALF_PF,
  output logic [7:0] O_CALCAP_EN,
  output logic [3:0] O_TX_DIV,
  output logic [7:0] O_REF_HALT,
  output logic O_TRACK_SUB,
  output logic [1:0] O_SLIDER_FILT,
  output logic [7:0] O_BLOCKING,
  output logic O_WINDOW_OPEN,
  output logic O_POLL_ACK,
  // per-channel calcap enables
  input wire logic [7:0] I_CH_CALCAP_EN
);
  import stgc_pkg::*;

  //------------------------------------------------
  // registers
  //------------------------------------------------
  logic [15:0] rates_lp_reg, rates_ulp_reg, timeouts_reg;
  logic [15:0] global_reg, refch_reg, block_reg, ulp_upd_reg, reseed_en_reg;

  // register writes
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rates_lp_reg <= STGC_RST_RATES_LP;
      rates_ulp_reg <= STGC_RST_RATES_ULP;
      timeouts_reg <= STGC_RST_TIMEOUTS;
      global_reg <= STGC_RST_GLOBAL;
      refch_reg <= STGC_RST_REFCH;
      block_reg <= STGC_RST_BLOCK;
      ulp_upd_reg <= STGC_RST_ULP_UPD;
      reseed_en_reg <= STGC_RST_RESEED_EN;
    end else if (I_REQ.wr) begin
      unique case (I_REQ.addr)
        STGC_OFS_RATES_LP: rates_lp_reg <= I_REQ.wdata;
        STGC_OFS_RATES_ULP: rates_ulp_reg <= I_REQ.wdata;
        STGC_OFS_TIMEOUTS: timeouts_reg <= I_REQ.wdata;
        STGC_OFS_GLOBAL: global_reg <= I_REQ.wdata;
        STGC_OFS_REFCH: refch_reg <= {I_REQ.wdata[15:8], 8'h00};
        STGC_OFS_BLOCK: block_reg <= {8'h00, I_REQ.wdata[7:0]};
        STGC_OFS_ULP_UPD: ulp_upd_reg <= {13'h0000, I_REQ.wdata[2:0]};
        STGC_OFS_RESEED_EN: reseed_en_reg <= {8'h00, I_REQ.wdata[7:0]};
        default: ;
      endcase
    end
  end

  // read decode
  logic [15:0] rd_mux;
  assign rd_mux = (I_REQ.addr == STGC_OFS_RATES_LP) ? rates_lp_reg :
                  (I_REQ.addr == STGC_OFS_RATES_ULP) ? rates_ulp_reg :
                  (I_REQ.addr == STGC_OFS_TIMEOUTS) ? timeouts_reg :
                  (I_REQ.addr == STGC_OFS_GLOBAL) ? global_reg :
                  (I_REQ.addr == STGC_OFS_REFCH) ? refch_reg :
                  (I_REQ.addr == STGC_OFS_BLOCK) ? block_reg :
                  (I_REQ.addr == STGC_OFS_ULP_UPD) ? ulp_upd_reg :
                  (I_REQ.addr == STGC_OFS_RESEED_EN) ? reseed_en_reg : 16'h0000;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA <= 16'h0000;
      O_RVALID <= 1'b0;
    end else begin
      O_RDATA <= I_REQ.rd ? rd_mux : O_RDATA;
      O_RVALID <= I_REQ.rd;
    end
  end

  //------------------------------------------------
  // half-millisecond time base
  //------------------------------------------------
  logic [31:0] pre_reg;
  logic tick;
  assign tick = (pre_reg == 32'(TICK_CYC - 1));
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) pre_reg <= 32'h0000_0000;
    else pre_reg <= tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
  end

  // second half-ms tick gives the 1 ms step
  logic ms_reg;
  logic ms_tick;
  assign ms_tick = tick & ms_reg;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) ms_reg <= 1'b0;
    else if (tick) ms_reg <= ~ms_reg;
  end

  //------------------------------------------------
  // power mode and sampling period
  //------------------------------------------------
  stgc_mode_t mode_reg, mode_next;
  logic user_event;
  logic [31:0] per_cnt_reg, per_len, mode_cnt_reg, mode_len;
  assign user_event = |I_SENSE.ch_event;
  // a period of 0 runs best effort: a tick each millisecond
  assign per_len = (mode_reg == STGC_ULP) ?
      32'(rates_ulp_reg[7:0]) * 32'(STGC_ULP_STEP_MS) :
      32'(rates_lp_reg[15:8]);
  assign mode_len = 32'(rates_ulp_reg[15:8]) * 32'(STGC_LONG_STEP_MS);
  // mode steps downward only; any user event returns to normal
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      STGC_NP: mode_next = STGC_LP;
      STGC_LP: mode_next = STGC_ULP;
      STGC_ULP: mode_next = STGC_ULP;
    endcase
  end

  logic mode_expire;
  assign mode_expire = ms_tick && (mode_cnt_reg + 32'h1 >= mode_len) && (mode_len != 32'h0);
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mode_reg <= STGC_NP;
      mode_cnt_reg <= 32'h0;
    end else if (user_event) begin
      mode_reg <= STGC_NP;
      mode_cnt_reg <= 32'h0;
    end else if (mode_expire) begin
      mode_reg <= mode_next;
      mode_cnt_reg <= 32'h0;
    end else if (ms_tick) begin
      mode_cnt_reg <= mode_cnt_reg + 32'h1;
    end
  end

  // sample period counter in ms, normal mode free-runs at each ms
  logic per_done;
  assign per_done = ms_tick && (per_cnt_reg + 32'h1 >= per_len);
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      per_cnt_reg <= 32'h0;
      O_SAMPLE_TICK <= 1'b0;
    end else begin
      O_SAMPLE_TICK <= (mode_reg == STGC_NP) ? ms_tick : per_done;
      if (per_done || mode_reg == STGC_NP) per_cnt_reg <= 32'h0;
      else if (ms_tick) per_cnt_reg <= per_cnt_reg + 32'h1;
    end
  end

  // ulp: wake channel each cycle, others every (update rate + 1)th cycle
  logic [2:0] upd_cnt_reg;
  logic upd_due;
  assign upd_due = (upd_cnt_reg >= ulp_upd_reg[2:0]);
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      upd_cnt_reg <= 3'h0;
      O_SENSE_MASK <= 8'hff;
    end else if (I_SAMPLE_START) begin
      upd_cnt_reg <= upd_due ? 3'h0 : upd_cnt_reg + 3'h1;
      O_SENSE_MASK <= (mode_reg == STGC_ULP && !upd_due) ? 8'h01 : 8'hff;
    end
  end

  //------------------------------------------------
  // host attention window and poll answer
  //------------------------------------------------
  logic [7:0] win_cnt_reg;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      win_cnt_reg <= 8'h00;
      O_WINDOW_OPEN <= 1'b0;
      O_POLL_ACK <= 1'b0;
    end else begin
      O_POLL_ACK <= I_ADDR_POLL;
      if (I_SAMPLE_START) begin
        win_cnt_reg <= timeouts_reg[7:0];
        O_WINDOW_OPEN <= (timeouts_reg[7:0] != 8'h00);
      end else if (I_HOST_ACCESS) begin
        O_WINDOW_OPEN <= 1'b0;
        win_cnt_reg <= 8'h00;
      end else if (tick && win_cnt_reg != 8'h00) begin
        win_cnt_reg <= win_cnt_reg - 8'h01;
        O_WINDOW_OPEN <= (win_cnt_reg != 8'h01);
      end
    end
  end

  //------------------------------------------------
  // halt time-out and reseeds
  //------------------------------------------------
  logic [31:0] halt_cnt_reg, halt_len;
  logic halt_off, halt_expire, ev_reseed_ch;
  assign halt_off = (timeouts_reg[15:8] == STGC_HALT_NEVER);
  assign halt_len = 32'(timeouts_reg[15:8]) * 32'(STGC_LONG_STEP_MS);
  assign ev_reseed_ch = |(I_SENSE.ch_event & reseed_en_reg[7:0]);
  assign halt_expire = !halt_off && ms_tick && (halt_cnt_reg + 32'h1 >= halt_len);
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) halt_cnt_reg <= 32'h0;
    else if (ev_reseed_ch || halt_expire || halt_off) halt_cnt_reg <= 32'h0;
    else if (ms_tick) halt_cnt_reg <= halt_cnt_reg + 32'h1;
  end

  // reference reseed: per-channel allowance from level code
  logic [1:0] lvl;
  logic track_en;
  logic [7:0] ref_fire, lvl_ok;
  assign lvl = refch_reg[STGC_R_RESEED_LVL +: 2];
  assign track_en = refch_reg[STGC_R_TRACK_EN];
  assign ref_fire = (|I_SENSE.ref_event && !track_en) ? I_SENSE.ref_assoc : 8'h00;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_lvl
      // touch implies prox is in or above; code 11 always reseeds
      assign lvl_ok[g] = (lvl == 2'b11) ||
          (!I_SENSE.ch_state_touch[g] && (!I_SENSE.ch_state_prox[g] || lvl != 2'b00)) ||
          (I_SENSE.ch_state_touch[g] && lvl == 2'b10);
    end
  endgenerate

  // reseed pulse tells the core to load average with count
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) O_RESEED <= 8'h00;
    else O_RESEED <= (halt_expire ? reseed_en_reg[7:0] : 8'h00) | (ref_fire & lvl_ok);
  end

  //------------------------------------------------
  // static configuration outputs
  //------------------------------------------------
  logic [2:0] tsel;
  logic [7:0] assoc_active;
  assign tsel = global_reg[STGC_G_TOUCH_SEL +: 3];
  assign assoc_active = I_SENSE.ref_assoc & (I_SENSE.ch_state_prox | I_SENSE.ch_state_touch);
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_MODE <= 2'h0;
      O_TUNE_EN <= 1'b0;
      O_TUNE_RETRY <= 1'b0;
      O_BAND_SHIFT <= 4'h3;
      O_CNT_FILT_BYPASS <= 1'b0;
      O_TOUCH_FLAG <= 1'b0;
      O_TOUCH_FLAG_OE <= 1'b0;
      O_BIDIR <= 1'b0;
      O_FREEZE_UP <= 1'b0;
      O_CALCAP_HALF_PF <= 4'h1;
      O_CALCAP_EN <= 8'h00;
      O_TX_DIV <= 4'h1;
      O_REF_HALT <= 8'h00;
      O_TRACK_SUB <= 1'b0;
      O_SLIDER_FILT <= 2'h0;
      O_BLOCKING <= 8'h00;
    end else begin
      O_MODE <= mode_reg;
      O_TUNE_EN <= I_TUNE_REQ && (!global_reg[STGC_G_TUNE_LP] || mode_reg == STGC_LP);
      O_TUNE_RETRY <= I_TUNE_OUT_OF_BAND && !global_reg[STGC_G_BAND_CHK_DIS];
      O_BAND_SHIFT <= global_reg[STGC_G_BAND] ? 4'h4 : 4'h3;
      O_CNT_FILT_BYPASS <= global_reg[STGC_G_CNT_FILT_DIS];
      // open drain, active low: drive low while selected channel is touched
      O_TOUCH_FLAG <= 1'b0;
      O_TOUCH_FLAG_OE <= I_SENSE.ch_state_touch[tsel];
      O_BIDIR <= global_reg[STGC_G_BIDIR];
      O_FREEZE_UP <= global_reg[STGC_G_BIDIR];
      O_CALCAP_HALF_PF <= global_reg[STGC_G_CALCAP] ? 4'h3 : 4'h1;
      O_CALCAP_EN <= I_CH_CALCAP_EN;
      O_TX_DIV <= 4'h1 << global_reg[STGC_G_TXDIV +: 2];
      O_REF_HALT <= track_en ? assoc_active : 8'h00;
      O_TRACK_SUB <= track_en && (|assoc_active);
      O_SLIDER_FILT <= refch_reg[STGC_R_SLIDER_FILT +: 2];
      O_BLOCKING <= block_reg[7:0];
    end
  end

  //------------------------------------------------
  // checks
  //------------------------------------------------
  sequence s_event;
    user_event;
  endsequence
  sequence s_back_np;
    ##1 (mode_reg == STGC_NP) && (mode_cnt_reg == 32'h0);
  endsequence

  AST_EVENT_RESTART: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    s_event |-> s_back_np) else $error("mode timer not restarted");
  AST_MODE_STEP: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (mode_expire && !user_event && mode_reg == STGC_NP) |=> mode_reg == STGC_LP)
    else $error("mode did not step");
  AST_HALT_NEVER: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    halt_off |=> (halt_cnt_reg == 32'h0)) else $error("halt timer ran while disabled");
  AST_HALT_RESEED: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    halt_expire |=> (O_RESEED & reseed_en_reg[7:0]) == reseed_en_reg[7:0])
    else $error("halt reseed missing");
  AST_TRACK_BLOCKS: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (track_en && !halt_expire) |=> O_RESEED == 8'h00) else $error("reseed while tracking");
  AST_TUNE_LP: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (global_reg[STGC_G_TUNE_LP] && mode_reg != STGC_LP) |=> !O_TUNE_EN)
    else $error("tuning outside low power");
  AST_ULP_MASK: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_SAMPLE_START && mode_reg == STGC_ULP && !upd_due) |=> O_SENSE_MASK == 8'h01)
    else $error("ulp sensed other channels");
  AST_POLL: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    I_ADDR_POLL |=> O_POLL_ACK) else $error("poll not answered");
  AST_TXDIV: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    $stable(global_reg) |-> O_TX_DIV == (4'h1 << global_reg[STGC_G_TXDIV +: 2]))
    else $error("divider wrong");

  // window and mode stepping; a sample start outranks a host access
  sequence s_win_shut;
    ##1 !O_WINDOW_OPEN && (win_cnt_reg == 8'h00);
  endsequence
  AST_WIN_SHUT: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_HOST_ACCESS && !I_SAMPLE_START) |-> s_win_shut) else $error("window not closed");
  AST_WIN_LOAD: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_SAMPLE_START && timeouts_reg[7:0] != 8'h00) |=> O_WINDOW_OPEN)
    else $error("window not opened");
  AST_ULP_STEP: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (mode_expire && !user_event && mode_reg == STGC_LP) |=> mode_reg == STGC_ULP)
    else $error("mode did not reach ulp");
endmodule : stgc_top
`default_nettype wire

// ===== verilog/stgc_pkg.sv
// package of constants and types for the sense timing and global config block
package stgc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] STGC_OFS_RATES_LP = 8'h83;
  localparam logic [7:0] STGC_OFS_RATES_ULP = 8'h84;
  localparam logic [7:0] STGC_OFS_TIMEOUTS = 8'h85;
  localparam logic [7:0] STGC_OFS_GLOBAL = 8'h86;
  localparam logic [7:0] STGC_OFS_REFCH = 8'h87;
  localparam logic [7:0] STGC_OFS_BLOCK = 8'h88;
  localparam logic [7:0] STGC_OFS_ULP_UPD = 8'h80;
  localparam logic [7:0] STGC_OFS_RESEED_EN = 8'h82;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] STGC_RST_RATES_LP = 16'h1010;
  localparam logic [15:0] STGC_RST_RATES_ULP = 16'h0810;
  localparam logic [15:0] STGC_RST_TIMEOUTS = 16'hff14;
  localparam logic [15:0] STGC_RST_GLOBAL = 16'h0000;
  localparam logic [15:0] STGC_RST_REFCH = 16'h0000;
  localparam logic [15:0] STGC_RST_BLOCK = 16'h0000;
  localparam logic [15:0] STGC_RST_ULP_UPD = 16'h0000;
  localparam logic [15:0] STGC_RST_RESEED_EN = 16'h00ff;
  // ----------------------------------------
  // field positions of the global settings word
  // ----------------------------------------
  localparam int STGC_G_TOUCH_SEL = 0;
  localparam int STGC_G_CNT_FILT_DIS = 4;
  localparam int STGC_G_BAND = 5;
  localparam int STGC_G_TUNE_LP = 6;
  localparam int STGC_G_BAND_CHK_DIS = 7;
  localparam int STGC_G_CALCAP = 8;
  localparam int STGC_G_TXDIV = 12;
  localparam int STGC_G_BIDIR = 14;
  // fields of the reference channel settings high byte
  localparam int STGC_R_SLIDER_FILT = 8;
  localparam int STGC_R_TRACK_EN = 12;
  localparam int STGC_R_RESEED_LVL = 14;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int STGC_CLK_MHZ = 125;
  localparam int STGC_TICK_US = 500;
  localparam int STGC_TICK_CYC = STGC_TICK_US * STGC_CLK_MHZ;
  localparam int STGC_MS_TICKS = 2;
  localparam int STGC_ULP_STEP_MS = 16;
  localparam int STGC_LONG_STEP_MS = 512;
  localparam logic [7:0] STGC_HALT_NEVER = 8'hff;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {STGC_NP, STGC_LP, STGC_ULP} stgc_mode_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } stgc_req_t;
  typedef struct packed {
    logic [7:0] ch_state_prox;
    logic [7:0] ch_state_touch;
    logic [7:0] ch_event;
    logic [7:0] ref_event;
    logic [7:0] ref_assoc;
  } stgc_sense_t;
endpackage : stgc_pkg

// ===== tb/stgc_host_model.sv
// host-side model: register requests, address polls and window accesses
`timescale 1ns/1ps
`default_nettype none
module stgc_host_model (
  // clock
  input wire logic i_clk,
  // requests toward the block
  output var stgc_pkg::stgc_req_t o_req,
  output logic o_addr_poll,
  output logic o_host_access,
  // read answers
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid
);
  import stgc_pkg::*;
  // idle lines start at a pattern, never at a plausible request
  initial begin
    o_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h5a, wdata: 16'ha5a5};
    o_addr_poll = 1'b0;
    o_host_access = 1'b0;
  end
  // released lines show the inverse of the last value so stale data cannot pass
  task automatic release_bus;
    o_req.wr = 1'b0;
    o_req.rd = 1'b0;
    o_req.addr = ~o_req.addr;
    o_req.wdata = ~o_req.wdata;
  endtask : release_bus
  // one-cycle write strobe, taken at the rising edge
  task automatic write(input logic [7:0] a, input logic [15:0] v);
    @(negedge i_clk);
    o_req.addr = a;
    o_req.wdata = v;
    o_req.wr = 1'b1;
    @(negedge i_clk);
    release_bus();
  endtask : write
  // read strobe, answer sampled while the valid pulse stands
  task automatic read(input logic [7:0] a, output logic [15:0] v);
    int k;
    @(negedge i_clk);
    o_req.addr = a;
    o_req.rd = 1'b1;
    @(negedge i_clk);
    release_bus();
    k = 0;
    while (i_rvalid !== 1'b1 && k < 4) begin
      @(negedge i_clk);
      k++;
    end
    v = (i_rvalid === 1'b1) ? i_rdata : 16'hxxxx;
  endtask : read
  // address poll or window access, one cycle
  task automatic strobe(input logic poll);
    @(negedge i_clk);
    o_addr_poll = poll;
    o_host_access = ~poll;
    @(negedge i_clk);
    o_addr_poll = 1'b0;
    o_host_access = 1'b0;
  endtask : strobe
endmodule : stgc_host_model
`default_nettype wire

// ===== tb/tb_stgc_top.sv
// self-checking bench of the sense timing and global config block
`timescale 1ns/1ps
`default_nettype none
module tb_stgc_top;
  import stgc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int TC = 4;
  localparam int MODE = STGC_LONG_STEP_MS * STGC_MS_TICKS * TC;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  stgc_req_t req;
  stgc_sense_t sense = '0;
  logic poll, hacc, rvalid, tick, tune_en, retry, filt, tflag, toe, bidir, frz, trk, win, pack;
  logic start = 1'b0;
  logic tune_req = 1'b0;
  logic oob = 1'b0;
  logic [15:0] rdata, d;
  logic [1:0] mode, sfilt;
  logic [7:0] smask, reseed, cen, rhalt, blk, acc;
  logic [3:0] band, cap, txdiv;
  int mismatches = 0;
  int checks_done = 0;
  int g;
  logic [7:0] ofs [8] = '{STGC_OFS_ULP_UPD, STGC_OFS_RESEED_EN, STGC_OFS_RATES_LP,
    STGC_OFS_RATES_ULP, STGC_OFS_TIMEOUTS, STGC_OFS_GLOBAL, STGC_OFS_REFCH, STGC_OFS_BLOCK};
  logic [15:0] rst [8] = '{STGC_RST_ULP_UPD, STGC_RST_RESEED_EN, STGC_RST_RATES_LP,
    STGC_RST_RATES_ULP, STGC_RST_TIMEOUTS, STGC_RST_GLOBAL, STGC_RST_REFCH, STGC_RST_BLOCK};
  logic [7:0] lvl_exp [4] = '{8'hf1, 8'hf3, 8'hff, 8'hff};
  // clock at 125 MHz
  always #4 clk = ~clk;
  // ----------------------------------------
  // instances
  // ----------------------------------------
  stgc_top #(.TICK_CYC(TC), .NCH(8)) stgc_top_i (.I_CLK(clk), .I_RESETN(rst_n), .I_REQ(req),
    .O_RDATA(rdata), .O_RVALID(rvalid), .I_SENSE(sense), .I_ADDR_POLL(poll),
    .I_HOST_ACCESS(hacc), .I_SAMPLE_START(start), .I_TUNE_REQ(tune_req),
    .I_TUNE_OUT_OF_BAND(oob), .O_MODE(mode), .O_SAMPLE_TICK(tick), .O_SENSE_MASK(smask),
    .O_RESEED(reseed), .O_TUNE_EN(tune_en), .O_TUNE_RETRY(retry), .O_BAND_SHIFT(band),
    .O_CNT_FILT_BYPASS(filt), .O_TOUCH_FLAG(tflag), .O_TOUCH_FLAG_OE(toe), .O_BIDIR(bidir),
    .O_FREEZE_UP(frz), .O_CALCAP_HALF_PF(cap), .O_CALCAP_EN(cen), .O_TX_DIV(txdiv),
    .O_REF_HALT(rhalt), .O_TRACK_SUB(trk), .O_SLIDER_FILT(sfilt), .O_BLOCKING(blk),
    .O_WINDOW_OPEN(win), .O_POLL_ACK(pack), .I_CH_CALCAP_EN(8'h5a));
  stgc_host_model stgc_host_model_i (.i_clk(clk), .o_req(req), .o_addr_poll(poll),
    .o_host_access(hacc), .i_rdata(rdata), .i_rvalid(rvalid));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string m);
    stgc_host_model_i.read(a, d);
    chk(d, e, m);
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    stgc_host_model_i.write(a, v);
    repeat (2) @(negedge clk);
  endtask : wr
  // reseed pulses last one cycle, so every cycle is folded in
  task automatic catch_reseed(input int n);
    acc = '0;
    repeat (n) begin
      acc |= reseed;
      @(negedge clk);
    end
  endtask : catch_reseed
  task automatic pulse_event(input logic ref_ch);
    @(negedge clk);
    if (ref_ch) sense.ref_event = 8'h01;
    else sense.ch_event = 8'h01;
    @(negedge clk);
    sense.ref_event = '0;
    sense.ch_event = '0;
  endtask : pulse_event
  // cycles between two sample ticks, bounded
  task automatic tick_gap(output int n);
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    n = 1;
    while (tick !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask : tick_gap
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // watchdog well beyond the longest timer sequence
  initial begin
    #(80000 * 8);
    mismatches++;
    give_verdict();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(16'({band, cap, txdiv}), 16'h0311, "reset outputs");
    chk(16'({smask, cen}), 16'hff5a, "mask and calcap enables");
    for (int i = 0; i < 8; i++) rdc(ofs[i], rst[i], "reset value");
    rdc(8'h00, 16'h0000, "unmapped read");
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(STGC_OFS_GLOBAL, 16'(i << STGC_G_TXDIV));
      chk(16'(txdiv), 16'(1 << i), "tx divider");
    end
    for (int j = 0; j < 2; j++) begin
      wr(STGC_OFS_GLOBAL, j ? 16'h41b5 : 16'h0000);
      rdc(STGC_OFS_GLOBAL, j ? 16'h41b5 : 16'h0000, "global readback");
      chk(16'(band), j ? 16'h4 : 16'h3, "band shift");
      chk(16'(filt), 16'(j), "filter bypass");
      chk(16'(cap), j ? 16'h3 : 16'h1, "calcap");
      chk(16'({bidir, frz}), j ? 16'h3 : 16'h0, "two-sided");
    end
    for (int c = 0; c < 8; c++) begin
      wr(STGC_OFS_GLOBAL, 16'(c));
      sense.ch_state_touch = 8'(1 << c);
      repeat (2) @(negedge clk);
      chk(16'({tflag, toe}), 16'h1, "touch flag on");
      sense.ch_state_touch = ~8'(1 << c);
      repeat (2) @(negedge clk);
      chk(16'({tflag, toe}), 16'h0, "touch flag off");
    end
    $display("test global settings done");
    tune_req = 1'b1;
    oob = 1'b1;
    wr(STGC_OFS_GLOBAL, 16'h0040);
    chk(16'(tune_en), 16'h0, "tuning outside low power");
    wr(STGC_OFS_GLOBAL, 16'h0000);
    chk(16'({tune_en, retry}), 16'h3, "tuning retry");
    wr(STGC_OFS_GLOBAL, 16'h0080);
    chk(16'(retry), 16'h0, "band check off");
    for (int i = 0; i < 4; i++) begin
      wr(STGC_OFS_REFCH, 16'(i << STGC_R_SLIDER_FILT) | 16'h00ff);
      chk(16'(sfilt), 16'(i), "slider filter");
      rdc(STGC_OFS_REFCH, 16'(i << STGC_R_SLIDER_FILT), "refch readback");
    end
    wr(STGC_OFS_BLOCK, 16'hffa5);
    rdc(STGC_OFS_BLOCK, 16'h00a5, "blocking readback");
    chk(16'(blk), 16'h00a5, "blocking enables");
    $display("test tuning and slider done");
    sense = '{ch_state_prox: 8'h0a, ch_state_touch: 8'h0c, default: 8'hff};
    sense.ch_event = '0;
    sense.ref_event = '0;
    for (int l = 0; l < 5; l++) begin
      if (l == 4) sense.ref_assoc = 8'h7f;
      wr(STGC_OFS_REFCH, 16'((l > 3 ? 3 : l) << STGC_R_RESEED_LVL));
      pulse_event(1'b1);
      catch_reseed(6);
      chk(16'(acc), l > 3 ? 16'h7f : 16'(lvl_exp[l]), "reference reseed");
    end
    wr(STGC_OFS_REFCH, 16'hd000);
    pulse_event(1'b1);
    catch_reseed(6);
    chk(16'({acc, 7'h0, trk}), 16'h0001, "tracking mode");
    chk(16'(rhalt), 16'h000e, "reference halt");
    sense = '0;
    $display("test reference channel done");
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'(win), 16'h1, "window opens");
    repeat (20 * TC - 14) @(negedge clk);
    chk(16'(win), 16'h1, "window still open");
    repeat (18) @(negedge clk);
    chk(16'(win), 16'h0, "window lapsed");
    stgc_host_model_i.strobe(1'b1);
    chk(16'(pack), 16'h1, "poll answered");
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    stgc_host_model_i.strobe(1'b0);
    @(negedge clk);
    chk(16'(win), 16'h0, "access closes window");
    $display("test window done");
    catch_reseed(MODE + 200);
    chk(16'(acc), 16'h0, "halt never");
    wr(STGC_OFS_RESEED_EN, 16'hff05);
    wr(STGC_OFS_TIMEOUTS, 16'h0114);
    catch_reseed(MODE + 200);
    chk(16'(acc), 16'h05, "halt reseed");
    wr(STGC_OFS_TIMEOUTS, STGC_RST_TIMEOUTS);
    $display("test halt done");
    wr(STGC_OFS_RATES_LP, 16'h0310);
    wr(STGC_OFS_RATES_ULP, 16'h0101);
    pulse_event(1'b0);
    chk(16'(mode), 16'(STGC_NP), "event returns np");
    repeat (MODE / 2) @(negedge clk);
    pulse_event(1'b0);
    repeat (MODE - 40) @(negedge clk);
    chk(16'(mode), 16'(STGC_NP), "timer restarted");
    repeat (80) @(negedge clk);
    chk(16'(mode), 16'(STGC_LP), "step to lp");
    tick_gap(g);
    chk(16'(g), 16'(3 * STGC_MS_TICKS * TC), "lp period");
    wr(STGC_OFS_GLOBAL, 16'h0040);
    chk(16'(tune_en), 16'h1, "tuning in lp");
    for (int k = 0; k < MODE + 200 && mode === 2'(STGC_LP); k++) @(negedge clk);
    chk(16'({mode, tune_en, smask[0]}), 16'h9, "ulp mode");
    wr(STGC_OFS_ULP_UPD, 16'h0002);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk(16'(smask), 16'h0001, "ulp wake channel only");
    tick_gap(g);
    chk(16'(g), 16'(STGC_ULP_STEP_MS * STGC_MS_TICKS * TC), "ulp period");
    pulse_event(1'b0);
    @(negedge clk);
    chk(16'(mode), 16'(STGC_NP), "event wakes");
    $display("test power modes done");
    give_verdict();
  end
endmodule : tb_stgc_top
`default_nettype wire
